// file: include/pit_defines.svh
/*
 * Constants of the prioritized interrupt and event transfer controller.
 * Assumes inclusion by pit_pkg.sv and the design files; definitions only.
 */
`ifndef PIT_DEFINES_SVH
`define PIT_DEFINES_SVH
`define PIT_NODES        18
`define PIT_CHANS        8
`define PIT_EXT          2
`define PIT_LVL_W        4
`define PIT_PTR_W        16
`define PIT_CNT_W        8
`define PIT_SEG_W        8
`define PIT_NUM_W        8
`define PIT_RESP_CYCLES  8
`define PIT_VEC_SHIFT    2
`define PIT_NUM_FIRST    8'h4d
`define PIT_NUM_LAST     8'h3f
`define PIT_PERIPH_MASK  18'h1f7ff
`define PIT_STEP_BYTE    16'h0001
`define PIT_STEP_WORD    16'h0002
`define PIT_CNT_ONE      8'h01
`endif

// file: include/pit_pkg.sv
/*
 * Types shared by the controller and its edge detector.
 * Assumes pit_defines.svh is on the include path.
 */
`include "pit_defines.svh"
package pit_pkg;
	typedef enum logic [1:0] {PIT_IDLE, PIT_WAIT} pit_state_e_t;
	typedef enum logic [1:0] {PIT_EDGE_OFF, PIT_EDGE_RISE, PIT_EDGE_FALL, PIT_EDGE_BOTH} pit_edge_t;
endpackage

// file: design/pit_edge_detect.sv
/*
 * Synchroniser and programmable edge detector for one fast external input.
 * Assumes PIN is asynchronous to CLOCK and MODE is quasi-static.
 */
`timescale 1ns/1ps
`include "pit_defines.svh"
module pit_edge_detect (
	input  wire logic              CLOCK,
	input  wire logic              SYS_RST,
	input  wire logic              PIN,
	input  wire pit_pkg::pit_edge_t MODE,
	output logic                   EDGE
);
	import pit_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic ev;
	} pit_edge_state_t;

	pit_edge_state_t r_reg;
	pit_edge_state_t r_next;

	always_comb begin
		r_next = r_reg;
		r_next.s1 = PIN;
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		case (MODE)
			PIT_EDGE_RISE: r_next.ev = r_reg.s2 & ~r_reg.s3;
			PIT_EDGE_FALL: r_next.ev = ~r_reg.s2 & r_reg.s3;
			PIT_EDGE_BOTH: r_next.ev = r_reg.s2 ^ r_reg.s3;
			default:       r_next.ev = 1'b0;
		endcase
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign EDGE = r_reg.ev;

	edge_select_a: assert property (@(posedge CLOCK) disable iff (SYS_RST)
		EDGE |-> (MODE == PIT_EDGE_BOTH)
			|| (MODE == PIT_EDGE_RISE && $past(r_reg.s2) && !$past(r_reg.s3))
			|| (MODE == PIT_EDGE_FALL && !$past(r_reg.s2) && $past(r_reg.s3)))
		else $error("edge pulse does not match the selected edge");
endmodule

// file: design/pit_ctrl.sv
/*
 * Prioritized interrupt controller with eight event transfer channels.
 * Assumes the CPU reports its current service level and global enable, takes
 * INT_BRANCH as a branch order, and completes each XFER_REQ in one cycle.
 */
`timescale 1ns/1ps
`include "pit_defines.svh"
module pit_ctrl #(
	parameter int RESP_CYCLES = `PIT_RESP_CYCLES
) (
	input  wire logic                                CLOCK,
	input  wire logic                                SYS_RST,
	input  wire logic [`PIT_NODES-1:0]               PERIPH_REQ,
	input  wire logic [`PIT_EXT-1:0]                 EXT_IN,
	input  wire logic [`PIT_EXT-1:0][1:0]            EXT_MODE,
	input  wire logic                                NODE_WE,
	input  wire logic [4:0]                          NODE_SEL,
	input  wire logic [`PIT_LVL_W-1:0]               NODE_LEVEL,
	input  wire logic                                NODE_ENABLE,
	input  wire logic                                NODE_TO_CHANNEL,
	input  wire logic [2:0]                          NODE_CHANNEL,
	input  wire logic                                NODE_SET_REQ,
	input  wire logic                                NODE_CLR_REQ,
	input  wire logic                                CHAN_WE,
	input  wire logic [2:0]                          CHAN_SEL,
	input  wire logic [`PIT_PTR_W-1:0]               CHAN_SRC,
	input  wire logic [`PIT_PTR_W-1:0]               CHAN_DST,
	input  wire logic [`PIT_CNT_W-1:0]               CHAN_COUNT,
	input  wire logic                                CHAN_INC_SRC,
	input  wire logic                                CHAN_INC_DST,
	input  wire logic                                CHAN_WORD,
	input  wire logic                                CHAN_CONT,
	input  wire logic [`PIT_SEG_W-1:0]               VECTOR_SEGMENT_SELECT,
	input  wire logic [1:0]                          VECTOR_SPACING_FIELD,
	input  wire logic [`PIT_LVL_W-1:0]               CPU_LEVEL,
	input  wire logic                                CPU_INT_EN,
	input  wire logic                                TRAP_REQ,
	input  wire logic [`PIT_NUM_W-1:0]               TRAP_NUM,
	output logic                                     INT_BUSY,
	output logic                                     INT_BRANCH,
	output logic [`PIT_SEG_W+`PIT_PTR_W-1:0]         INT_VECTOR,
	output logic [`PIT_NUM_W-1:0]                    INT_NUMBER,
	output logic [`PIT_LVL_W-1:0]                    INT_LEVEL,
	output logic                                     XFER_REQ,
	output logic [`PIT_PTR_W-1:0]                    XFER_SRC,
	output logic [`PIT_PTR_W-1:0]                    XFER_DST,
	output logic                                     XFER_WORD,
	output logic [`PIT_NODES-1:0]                    NODE_REQ_STATUS,
	output logic [`PIT_CHANS-1:0]                    CHAN_ZERO
);
	import pit_pkg::*;

	localparam int NODES = `PIT_NODES;
	localparam int CHANS = `PIT_CHANS;
	localparam int IW    = 5;

	typedef struct packed {
		pit_state_e_t                               st;
		logic [3:0]                                 cnt;
		logic [NODES-1:0]                           ir;
		logic [NODES-1:0]                           ie;
		logic [NODES-1:0]                           pe;
		logic [NODES-1:0][`PIT_LVL_W-1:0]           lvl;
		logic [NODES-1:0][2:0]                      chs;
		logic [CHANS-1:0][`PIT_PTR_W-1:0]           src;
		logic [CHANS-1:0][`PIT_PTR_W-1:0]           dst;
		logic [CHANS-1:0][`PIT_CNT_W-1:0]           tcnt;
		logic [CHANS-1:0]                           isrc;
		logic [CHANS-1:0]                           idst;
		logic [CHANS-1:0]                           word;
		logic [CHANS-1:0]                           cont;
		logic                                       trp;
		logic                                       br;
		logic [`PIT_SEG_W+`PIT_PTR_W-1:0]           vec;
		logic [`PIT_NUM_W-1:0]                      num;
		logic [`PIT_LVL_W-1:0]                      wlvl;
		logic                                       tx;
		logic [`PIT_PTR_W-1:0]                      txs;
		logic [`PIT_PTR_W-1:0]                      txd;
		logic                                       txw;
	} pit_ctrl_state_t;

	pit_ctrl_state_t r_reg;
	pit_ctrl_state_t r_next;

	logic [`PIT_EXT-1:0]      ext_evt;
	logic [IW+`PIT_LVL_W:0]   win;
	logic                     win_found;
	logic [IW-1:0]            win_idx;
	logic [`PIT_LVL_W-1:0]    win_lvl;
	logic [2:0]               wch;
	logic                     go;
	logic                     use_xfer;
	logic                     take_int;
	logic [`PIT_CNT_W-1:0]    cnt_dec;
	logic [`PIT_PTR_W-1:0]    step;

	// Fixed numbering: nodes 0..16 count up from 4D, the last node is 3F.
	function automatic logic [`PIT_NUM_W-1:0] node_num(input logic [IW-1:0] idx);
		if (idx == IW'(NODES - 1)) begin
			return `PIT_NUM_LAST;
		end
		return `PIT_NUM_FIRST + `PIT_NUM_W'(idx);
	endfunction

	// Spacing field 0 keeps the default four bytes; each step doubles it.
	function automatic logic [`PIT_SEG_W+`PIT_PTR_W-1:0] vec_addr(
		input logic [`PIT_NUM_W-1:0] num,
		input logic [`PIT_SEG_W-1:0] seg,
		input logic [1:0]            sc);
		logic [`PIT_PTR_W-1:0] off;
		off = `PIT_PTR_W'(num) << (`PIT_VEC_SHIFT + int'(sc));
		return {seg, off};
	endfunction

	// A strictly greater level replaces the candidate, so ties keep the lowest index.
	function automatic logic [IW+`PIT_LVL_W:0] pit_arb(
		input logic [NODES-1:0]                 p,
		input logic [NODES-1:0][`PIT_LVL_W-1:0] l);
		logic                  f;
		logic [IW-1:0]         ix;
		logic [`PIT_LVL_W-1:0] bl;
		f  = 1'b0;
		ix = '0;
		bl = '0;
		for (int i = 0; i < NODES; i++) begin
			if (p[i] && (!f || l[i] > bl)) begin
				f  = 1'b1;
				ix = IW'(i);
				bl = l[i];
			end
		end
		return {f, ix, bl};
	endfunction

	for (genvar g = 0; g < `PIT_EXT; g++) begin : g_ext
		pit_edge_detect u_edge (
			.CLOCK   (CLOCK),
			.SYS_RST (SYS_RST),
			.PIN     (EXT_IN[g]),
			.MODE    (pit_edge_t'(EXT_MODE[g])),
			.EDGE    (ext_evt[g])
		);
	end

	assign win       = pit_arb(r_reg.ir & r_reg.ie, r_reg.lvl);
	assign win_found = win[IW+`PIT_LVL_W];
	assign win_idx   = win[IW+`PIT_LVL_W-1:`PIT_LVL_W];
	assign win_lvl   = win[`PIT_LVL_W-1:0];
	assign wch       = r_reg.chs[win_idx];
	assign go        = r_reg.st == PIT_IDLE && !TRAP_REQ && win_found && CPU_INT_EN
		&& win_lvl > CPU_LEVEL;
	assign use_xfer  = go && r_reg.pe[win_idx]
		&& (r_reg.tcnt[wch] != '0 || r_reg.cont[wch]);
	assign take_int  = go && !use_xfer;
	assign cnt_dec   = r_reg.tcnt[wch] - `PIT_CNT_ONE;
	assign step      = r_reg.word[wch] ? `PIT_STEP_WORD : `PIT_STEP_BYTE;

	always_comb begin
		r_next    = r_reg;
		r_next.br = 1'b0;
		r_next.tx = 1'b0;
		case (r_reg.st)
			PIT_IDLE: begin
				if (TRAP_REQ) begin
					r_next.st   = PIT_WAIT;
					r_next.cnt  = 4'(RESP_CYCLES - 1);
					r_next.trp  = 1'b1;
					r_next.num  = TRAP_NUM;
					r_next.wlvl = CPU_LEVEL;
					r_next.vec  = vec_addr(TRAP_NUM, VECTOR_SEGMENT_SELECT,
						VECTOR_SPACING_FIELD);
				end else if (use_xfer) begin
					// The CPU keeps running; only one bus cycle is taken.
					r_next.tx  = 1'b1;
					r_next.txs = r_reg.src[wch];
					r_next.txd = r_reg.dst[wch];
					r_next.txw = r_reg.word[wch];
					if (r_reg.isrc[wch]) begin
						r_next.src[wch] = r_reg.src[wch] + step;
					end
					if (r_reg.idst[wch]) begin
						r_next.dst[wch] = r_reg.dst[wch] + step;
					end
					if (!r_reg.cont[wch]) begin
						r_next.tcnt[wch] = cnt_dec;
					end
					// A request left pending here is vectored on the next pass.
					r_next.ir[win_idx] = !r_reg.cont[wch] && cnt_dec == '0;
				end else if (take_int) begin
					r_next.st          = PIT_WAIT;
					r_next.cnt         = 4'(RESP_CYCLES - 1);
					r_next.trp         = 1'b0;
					r_next.ir[win_idx] = 1'b0;
					r_next.num         = node_num(win_idx);
					r_next.wlvl        = win_lvl;
					r_next.vec         = vec_addr(node_num(win_idx), VECTOR_SEGMENT_SELECT,
						VECTOR_SPACING_FIELD);
				end
			end
			PIT_WAIT: begin
				if (r_reg.cnt == '0) begin
					r_next.br = 1'b1;
					r_next.st = PIT_IDLE;
				end else begin
					r_next.cnt = r_reg.cnt - 4'h1;
				end
			end
			default: begin
				r_next.st = PIT_IDLE;
			end
		endcase
		if (NODE_WE) begin
			r_next.lvl[NODE_SEL] = NODE_LEVEL;
			r_next.ie[NODE_SEL]  = NODE_ENABLE;
			r_next.pe[NODE_SEL]  = NODE_TO_CHANNEL;
			r_next.chs[NODE_SEL] = NODE_CHANNEL;
			if (NODE_CLR_REQ) begin
				r_next.ir[NODE_SEL] = 1'b0;
			end
			if (NODE_SET_REQ) begin
				r_next.ir[NODE_SEL] = 1'b1;
			end
		end
		if (CHAN_WE) begin
			r_next.src[CHAN_SEL]  = CHAN_SRC;
			r_next.dst[CHAN_SEL]  = CHAN_DST;
			r_next.tcnt[CHAN_SEL] = CHAN_COUNT;
			r_next.isrc[CHAN_SEL] = CHAN_INC_SRC;
			r_next.idst[CHAN_SEL] = CHAN_INC_DST;
			r_next.word[CHAN_SEL] = CHAN_WORD;
			r_next.cont[CHAN_SEL] = CHAN_CONT;
		end
		// Hardware sets come last so an event in a clearing cycle survives.
		r_next.ir = r_next.ir | (PERIPH_REQ & `PIT_PERIPH_MASK) | NODES'(ext_evt);
	end

	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign INT_BUSY        = r_reg.st == PIT_WAIT;
	assign INT_BRANCH      = r_reg.br;
	assign INT_VECTOR      = r_reg.vec;
	assign INT_NUMBER      = r_reg.num;
	assign INT_LEVEL       = r_reg.wlvl;
	assign XFER_REQ        = r_reg.tx;
	assign XFER_SRC        = r_reg.txs;
	assign XFER_DST        = r_reg.txd;
	assign XFER_WORD       = r_reg.txw;
	assign NODE_REQ_STATUS = r_reg.ir;
	for (genvar c = 0; c < CHANS; c++) begin : g_zero
		assign CHAN_ZERO[c] = r_reg.tcnt[c] == '0;
	end

	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);

	branch_delay_a: assert property ($rose(INT_BUSY) |-> !INT_BRANCH [*8] ##1 INT_BRANCH)
		else $error("branch not issued eight cycles after acceptance");
	xfer_steal_a: assert property (XFER_REQ |-> !INT_BUSY && !INT_BRANCH && !$past(INT_BUSY))
		else $error("event transfer entered the vector path");
	count_dec_a: assert property (use_xfer && !r_reg.cont[wch] && !CHAN_WE
		|=> r_reg.tcnt[$past(wch)] == $past(r_reg.tcnt[wch]) - `PIT_CNT_ONE)
		else $error("transfer counter did not decrement");
	count_hold_a: assert property (use_xfer && r_reg.cont[wch] && !CHAN_WE
		|=> r_reg.tcnt[$past(wch)] == $past(r_reg.tcnt[wch]))
		else $error("continuous mode changed the counter");
	src_step_a: assert property (use_xfer && r_reg.isrc[wch] && !CHAN_WE
		|=> XFER_SRC + (XFER_WORD ? `PIT_STEP_WORD : `PIT_STEP_BYTE) == r_reg.src[$past(wch)])
		else $error("source pointer step wrong");
	zero_vector_a: assert property (use_xfer && !r_reg.cont[wch]
		&& r_reg.tcnt[wch] == `PIT_CNT_ONE |=> NODE_REQ_STATUS[$past(win_idx)])
		else $error("exhausted channel did not keep the node request");
	preempt_level_a: assert property ($rose(INT_BUSY) && !r_reg.trp
		|-> INT_LEVEL > $past(CPU_LEVEL) && $past(CPU_INT_EN))
		else $error("service accepted without strictly higher level");
	default_vector_a: assert property (INT_BRANCH && $past(VECTOR_SPACING_FIELD, 9) == 2'h0
		|-> INT_VECTOR[`PIT_PTR_W-1:0] == {6'h00, INT_NUMBER, 2'h0})
		else $error("default vector is not number times four");
	sw_request_a: assert property (NODE_WE && NODE_SET_REQ |=> NODE_REQ_STATUS[$past(NODE_SEL)])
		else $error("software request bit was lost");
	trap_number_a: assert property (r_reg.st == PIT_IDLE && TRAP_REQ
		|=> INT_NUMBER == $past(TRAP_NUM) && INT_BUSY)
		else $error("trap did not select its own number");

	vectored_c: cover property ($rose(INT_BUSY) ##8 INT_BRANCH);
	xfer_c: cover property (XFER_REQ ##1 XFER_REQ);
	exhaust_c: cover property (use_xfer && r_reg.tcnt[wch] == `PIT_CNT_ONE ##1 XFER_REQ
		##[1:4] $rose(INT_BUSY));
	trap_c: cover property (TRAP_REQ && r_reg.st == PIT_IDLE);
endmodule

// file: tb/pit_cpu_model.sv
/*
 * Behavioural model of the CPU core and memory side facing pit_ctrl.
 * Assumes it shares CLOCK and SYS_RST with the controller.
 */
`timescale 1ns/1ps
module pit_cpu_model (
	input  wire logic       CLOCK,
	input  wire logic       SYS_RST,
	input  wire logic       INT_BUSY,
	input  wire logic [3:0] INT_LEVEL,
	input  wire logic       XFER_REQ,
	input  wire logic       RET,
	output logic      [3:0] CPU_LEVEL,
	output logic      [7:0] XFER_CNT
);
	// The core takes the new level while the branch is pending, so that an
	// equal request cannot slip in at the edge that ends the branch cycle.
	always_ff @(posedge CLOCK or posedge SYS_RST) begin
		if (SYS_RST) begin
			CPU_LEVEL <= 4'h0;
			XFER_CNT  <= 8'h00;
		end else begin
			if (INT_BUSY)
				CPU_LEVEL <= INT_LEVEL;
			else if (RET)
				CPU_LEVEL <= 4'h0;
			// Each transfer completes in the cycle in which it is asked for.
			if (XFER_REQ)
				XFER_CNT <= XFER_CNT + 8'h01;
		end
	end
endmodule

// file: tb/pit_ctrl_test.sv
/*
 * Self-checking bench for pit_ctrl with a behavioural CPU model.
 * Assumes pit_pkg and the design are compiled first; one 100 MHz clock.
 */
`timescale 1ns/1ps
module pit_ctrl_test;
	logic            CLOCK, SYS_RST, NODE_WE, NODE_ENABLE, NODE_TO_CHANNEL, NODE_SET_REQ;
	logic            NODE_CLR_REQ, CHAN_WE, CHAN_INC_SRC, CHAN_INC_DST, CHAN_WORD, CHAN_CONT;
	logic            CPU_INT_EN, TRAP_REQ, INT_BUSY, INT_BRANCH, XFER_REQ, XFER_WORD, RET;
	logic [17:0]     PERIPH_REQ, NODE_REQ_STATUS;
	logic [1:0]      EXT_IN, VECTOR_SPACING_FIELD;
	logic [1:0][1:0] EXT_MODE;
	logic [4:0]      NODE_SEL;
	logic [3:0]      NODE_LEVEL, CPU_LEVEL, INT_LEVEL;
	logic [2:0]      NODE_CHANNEL, CHAN_SEL;
	logic [15:0]     CHAN_SRC, CHAN_DST, XFER_SRC, XFER_DST;
	logic [7:0]      CHAN_COUNT, VECTOR_SEGMENT_SELECT, TRAP_NUM, INT_NUMBER, CHAN_ZERO, XFER_CNT;
	logic [23:0]     INT_VECTOR;
	int              errors, num_checks;

	pit_ctrl pit_ctrl_i (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .PERIPH_REQ(PERIPH_REQ),
		.EXT_IN(EXT_IN), .EXT_MODE(EXT_MODE), .NODE_WE(NODE_WE), .NODE_SEL(NODE_SEL),
		.NODE_LEVEL(NODE_LEVEL), .NODE_ENABLE(NODE_ENABLE), .NODE_TO_CHANNEL(NODE_TO_CHANNEL),
		.NODE_CHANNEL(NODE_CHANNEL), .NODE_SET_REQ(NODE_SET_REQ), .NODE_CLR_REQ(NODE_CLR_REQ),
		.CHAN_WE(CHAN_WE), .CHAN_SEL(CHAN_SEL), .CHAN_SRC(CHAN_SRC), .CHAN_DST(CHAN_DST),
		.CHAN_COUNT(CHAN_COUNT), .CHAN_INC_SRC(CHAN_INC_SRC), .CHAN_INC_DST(CHAN_INC_DST),
		.CHAN_WORD(CHAN_WORD), .CHAN_CONT(CHAN_CONT), .VECTOR_SEGMENT_SELECT(VECTOR_SEGMENT_SELECT),
		.VECTOR_SPACING_FIELD(VECTOR_SPACING_FIELD), .CPU_LEVEL(CPU_LEVEL),
		.CPU_INT_EN(CPU_INT_EN), .TRAP_REQ(TRAP_REQ), .TRAP_NUM(TRAP_NUM), .INT_BUSY(INT_BUSY),
		.INT_BRANCH(INT_BRANCH), .INT_VECTOR(INT_VECTOR), .INT_NUMBER(INT_NUMBER),
		.INT_LEVEL(INT_LEVEL), .XFER_REQ(XFER_REQ), .XFER_SRC(XFER_SRC), .XFER_DST(XFER_DST),
		.XFER_WORD(XFER_WORD), .NODE_REQ_STATUS(NODE_REQ_STATUS), .CHAN_ZERO(CHAN_ZERO));

	pit_cpu_model pit_cpu_model_i (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .INT_BUSY(INT_BUSY),
		.INT_LEVEL(INT_LEVEL), .XFER_REQ(XFER_REQ), .RET(RET), .CPU_LEVEL(CPU_LEVEL),
		.XFER_CNT(XFER_CNT));

	initial begin
		CLOCK = 1'b0;
		forever #5 CLOCK = ~CLOCK;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("Error at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask

	task automatic node_wr(input logic [4:0] sel, input logic [3:0] lvl, input logic en,
		input logic tc, input logic [2:0] ch, input logic set, input logic clr);
		@(posedge CLOCK);
		{NODE_WE, NODE_SEL, NODE_LEVEL, NODE_ENABLE, NODE_TO_CHANNEL, NODE_CHANNEL, NODE_SET_REQ,
			NODE_CLR_REQ} <= {1'b1, sel, lvl, en, tc, ch, set, clr};
		@(posedge CLOCK);
		NODE_WE <= 1'b0;
	endtask

	task automatic ch_wr(input logic [2:0] sel, input logic [15:0] src, input logic [15:0] dst,
		input logic [7:0] cnt, input logic [3:0] flags);
		@(posedge CLOCK);
		{CHAN_WE, CHAN_SEL, CHAN_SRC, CHAN_DST, CHAN_COUNT, CHAN_INC_SRC, CHAN_INC_DST, CHAN_WORD,
			CHAN_CONT} <= {1'b1, sel, src, dst, cnt, flags};
		@(posedge CLOCK);
		CHAN_WE <= 1'b0;
	endtask

	task automatic pulse(input int idx);
		@(posedge CLOCK);
		PERIPH_REQ[idx] <= 1'b1;
		@(posedge CLOCK);
		PERIPH_REQ[idx] <= 1'b0;
	endtask

	task automatic ret;
		@(posedge CLOCK);
		RET <= 1'b1;
		@(posedge CLOCK);
		RET <= 1'b0;
	endtask

	// Bounded waits: a lost request shows up as a mismatch, not as a hang.
	task automatic wait_int(input logic [7:0] num, input logic [23:0] v, input logic [3:0] lvl);
		int i;
		i = 0;
		#1;
		while (INT_BUSY !== 1'b1 && i < 40) begin
			tick(1);
			i++;
		end
		chk({INT_NUMBER, INT_LEVEL}, {num, lvl});
		chk(INT_VECTOR, v);
		repeat (8) begin
			chk({INT_BUSY, INT_BRANCH}, 2'b10);
			tick(1);
		end
		chk({INT_BUSY, INT_BRANCH}, 2'b01);
	endtask

	task automatic wait_xfer(input logic [15:0] src, input logic [15:0] dst, input logic word);
		int i;
		i = 0;
		#1;
		while (XFER_REQ !== 1'b1 && i < 40) begin
			tick(1);
			i++;
		end
		chk({XFER_SRC, XFER_DST}, {src, dst});
		chk({XFER_REQ, XFER_WORD, INT_BUSY}, {1'b1, word, 1'b0});
	endtask

	task automatic t_vectored;
		node_wr(5'd16, 4'h5, 1'b1, 1'b0, 3'h0, 1'b0, 1'b0);
		pulse(16);
		wait_int(8'h5d, 24'h000174, 4'h5);
		ret;
		node_wr(5'd17, 4'h3, 1'b1, 1'b0, 3'h0, 1'b1, 1'b0);
		wait_int(8'h3f, 24'h0000fc, 4'h3);
		ret;
	endtask

	task automatic t_trap;
		@(posedge CLOCK);
		{VECTOR_SEGMENT_SELECT, VECTOR_SPACING_FIELD, TRAP_NUM, TRAP_REQ} <= {8'ha5, 2'h2, 8'h3f, 1'b1};
		@(posedge CLOCK);
		TRAP_REQ <= 1'b0;
		wait_int(8'h3f, 24'ha503f0, 4'h0);
		@(posedge CLOCK);
		{VECTOR_SEGMENT_SELECT, VECTOR_SPACING_FIELD} <= 10'h000;
	endtask

	task automatic t_prio;
		@(posedge CLOCK);
		CPU_INT_EN <= 1'b0;
		node_wr(5'd6, 4'h9, 1'b1, 1'b0, 3'h0, 1'b1, 1'b0);
		node_wr(5'd5, 4'h9, 1'b1, 1'b0, 3'h0, 1'b1, 1'b0);
		@(posedge CLOCK);
		CPU_INT_EN <= 1'b1;
		wait_int(8'h52, 24'h000148, 4'h9);
		tick(12);
		chk({INT_BUSY, NODE_REQ_STATUS[6]}, 2'b01);
		node_wr(5'd7, 4'hf, 1'b1, 1'b0, 3'h0, 1'b1, 1'b0);
		wait_int(8'h54, 24'h000150, 4'hf);
		ret;
		wait_int(8'h53, 24'h00014c, 4'h9);
		ret;
	endtask

	task automatic t_xfer;
		ch_wr(3'h3, 16'h1000, 16'h2000, 8'h02, 4'b1010);
		node_wr(5'd2, 4'h6, 1'b1, 1'b1, 3'h3, 1'b0, 1'b0);
		pulse(2);
		wait_xfer(16'h1000, 16'h2000, 1'b1);
		pulse(2);
		wait_xfer(16'h1002, 16'h2000, 1'b1);
		wait_int(8'h4f, 24'h00013c, 4'h6);
		chk({CHAN_ZERO[3], XFER_CNT}, {1'b1, 8'h02});
		ret;
		ch_wr(3'h4, 16'h4000, 16'h3000, 8'h01, 4'b0101);
		node_wr(5'd3, 4'h4, 1'b1, 1'b1, 3'h4, 1'b0, 1'b0);
		for (int k = 0; k < 3; k++) begin
			pulse(3);
			wait_xfer(16'h4000, 16'h3000 + 16'(k), 1'b0);
		end
		tick(12);
		chk({CHAN_ZERO[4], INT_BUSY, XFER_CNT}, {2'b00, 8'h05});
	endtask

	task automatic t_edge;
		for (int m = 0; m < 4; m++) begin
			@(posedge CLOCK);
			EXT_MODE[1] <= m[1:0];
			EXT_IN[1] <= 1'b1;
			tick(8);
			chk(NODE_REQ_STATUS[1], m[0]);
			node_wr(5'd1, 4'h0, 1'b0, 1'b0, 3'h0, 1'b0, 1'b1);
			EXT_IN[1] <= 1'b0;
			tick(8);
			chk(NODE_REQ_STATUS[1], m[1]);
			node_wr(5'd1, 4'h0, 1'b0, 1'b0, 3'h0, 1'b0, 1'b1);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		errors = 0;
		num_checks = 0;
		SYS_RST = 1'b1;
		CPU_INT_EN = 1'b1;
		{NODE_WE, NODE_SEL, NODE_LEVEL, NODE_ENABLE, NODE_TO_CHANNEL, NODE_CHANNEL} = '0;
		{NODE_SET_REQ, NODE_CLR_REQ, CHAN_WE, CHAN_SEL, CHAN_SRC, CHAN_DST, CHAN_COUNT} = '0;
		{CHAN_INC_SRC, CHAN_INC_DST, CHAN_WORD, CHAN_CONT, TRAP_REQ, TRAP_NUM, RET} = '0;
		{PERIPH_REQ, EXT_IN, EXT_MODE, VECTOR_SEGMENT_SELECT, VECTOR_SPACING_FIELD} = '0;
		repeat (16) @(posedge CLOCK);
		SYS_RST <= 1'b0;
		tick(2);
		chk({CHAN_ZERO, NODE_REQ_STATUS, INT_BUSY, XFER_REQ}, {8'hff, 20'h00000});
		t_vectored;
		t_trap;
		t_prio;
		t_xfer;
		t_edge;
		end_of_test;
	end

	// The scenarios need well under two thousand cycles.
	initial begin
		repeat (20000) @(posedge CLOCK);
		errors++;
		end_of_test;
	end
endmodule
